// file: logic/instr_timing_map.svh
// Purpose: Cycle figures for the instruction timing model.
// Assumes: Figures are processor clock periods at the core clock.
// Notes: Row layout is {best, cache, worst, reads, worst prefetches, writes}.
`ifndef INSTR_TIMING_MAP_SVH
`define INSTR_TIMING_MAP_SVH

// Field positions inside a packed row figure
`define ROW_BEST_MSB 35
`define ROW_BEST_LSB 28
`define ROW_CACHE_MSB 27
`define ROW_CACHE_LSB 20
`define ROW_WORST_MSB 19
`define ROW_WORST_LSB 12
`define ROW_READS_MSB 11
`define ROW_READS_LSB 8
`define ROW_PF_MSB 7
`define ROW_PF_LSB 4
`define ROW_WRITES_MSB 3
`define ROW_WRITES_LSB 0

// Special-purpose alternate_space_move
`define ROW_EXCHANGE {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}
`define ROW_STATUS_TO_REG {8'h01, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0}
`define ROW_STATUS_TO_MEM {8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 4'h1}
`define ROW_OPERAND_TO_FLAGS {8'h04, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0}
`define ROW_OPERAND_TO_STATUS {8'h08, 8'h08, 8'h0B, 4'h0, 4'h2, 4'h0}
`define ROW_MULTI_LOAD {8'h08, 8'h08, 8'h09, 4'h0, 4'h1, 4'h0}
`define ROW_MULTI_STORE {8'h04, 8'h04, 8'h05, 4'h0, 4'h1, 4'h0}
`define ROW_ALT_LOAD {8'h07, 8'h07, 8'h08, 4'h1, 4'h1, 4'h0}
`define ROW_ALT_STORE {8'h05, 8'h05, 8'h07, 4'h0, 4'h1, 4'h1}
`define ROW_USP_MOVE {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}
`define ROW_SWAP {8'h01, 8'h04, 8'h04, 4'h0, 4'h1, 4'h0}
// Register-to-register and memory arithmetic/logical
`define ROW_ARITH_TO_REG {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}
`define ROW_ARITH_TO_MEM {8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1}
`define ROW_ADDR_COMPARE {8'h01, 8'h04, 8'h04, 4'h0, 4'h1, 4'h0}
`define ROW_BOUNDS {8'h10, 8'h12, 8'h12, 4'h1, 4'h1, 4'h0}
`define ROW_WORD_MUL {8'h19, 8'h1B, 8'h1C, 4'h0, 4'h1, 4'h0}
`define ROW_LONG_MUL {8'h29, 8'h2B, 8'h2C, 4'h0, 4'h1, 4'h0}
`define ROW_UWORD_DIV {8'h2A, 8'h2C, 8'h2C, 4'h0, 4'h1, 4'h0}
`define ROW_ULONG_DIV {8'h4C, 8'h4E, 8'h4F, 4'h0, 4'h1, 4'h0}
`define ROW_SWORD_DIV {8'h36, 8'h38, 8'h39, 4'h0, 4'h1, 4'h0}
`define ROW_SLONG_DIV {8'h58, 8'h5A, 8'h5B, 4'h0, 4'h1, 4'h0}
// Quick and immediate forms
`define ROW_QUICK_TO_REG {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}
`define ROW_QUICK_TO_MEM {8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1}
`define ROW_IMM_TO_REG {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}
`define ROW_IMM_TO_MEM {8'h03, 8'h04, 8'h06, 4'h0, 4'h1, 4'h1}
`define ROW_IMM_COMPARE {8'h00, 8'h02, 8'h03, 4'h0, 4'h1, 4'h0}

// Per-register cost of multi-register transfers
`define LOAD_CLOCKS_PER_REG 8'h04
`define STORE_CLOCKS_PER_REG 8'h03

// Reset values and the register-count limit
`define RESULT_RESET 44'h000_0000_0000
`define ACCUM_RESET 32'h0000_0000
`define MAX_REG_COUNT 5'h10

`endif

// file: logic/instr_timing_pkg.sv
// Purpose: Types shared by the instruction timing model.
// Assumes: Constants live in instr_timing_map.svh.
// Notes: Bus triple carries clocks plus read, prefetch and write counts.
package instr_timing_pkg;

	// Instruction classes covered by the model
	typedef enum logic [4:0] {
		CLS_EXCHANGE, CLS_STATUS_TO_REG, CLS_STATUS_TO_MEM, CLS_OPERAND_TO_FLAGS,
		CLS_OPERAND_TO_STATUS, CLS_MULTI_LOAD, CLS_MULTI_STORE, CLS_ALT_LOAD,
		CLS_ALT_STORE, CLS_USP_MOVE, CLS_SWAP, CLS_ARITH_TO_REG,
		CLS_ARITH_TO_MEM, CLS_ADDR_COMPARE, CLS_BOUNDS, CLS_WORD_MUL,
		CLS_LONG_MUL, CLS_UWORD_DIV, CLS_ULONG_DIV, CLS_SWORD_DIV,
		CLS_SLONG_DIV, CLS_QUICK_TO_REG, CLS_QUICK_TO_MEM, CLS_IMM_TO_REG,
		CLS_IMM_TO_MEM, CLS_IMM_COMPARE
	} instr_class_t;

	// Cache situation that selects the column
	typedef enum logic [1:0] {
		CASE_BEST, CASE_CACHE, CASE_WORST
	} timing_case_t;

	// Addressing-mode time to be added to the row
	typedef enum logic [2:0] {
		ADD_NONE, ADD_FETCH_ADDR, ADD_FETCH_IMM, ADD_CALC_ADDR, ADD_CALC_IMM
	} addon_kind_t;

	// Clock total with its embedded bus cycles
	typedef struct packed {
		logic [15:0] clocks;
		logic [7:0] reads;
		logic [7:0] prefetches;
		logic [7:0] writes;
	} bus_triple_t;

	// One timing query
	typedef struct packed {
		instr_class_t cls;
		timing_case_t tcase;
		logic [4:0] reg_count;
		bus_triple_t addr_time;
	} timing_req_t;

	// One timing answer
	typedef struct packed {
		bus_triple_t total;
		addon_kind_t addon;
		logic bad;
	} timing_res_t;

endpackage : instr_timing_pkg

// file: logic/instr_timing_model.sv
// Purpose: Cycle-accounting model for move, arithmetic, multiply, divide
//          and quick/immediate instruction groups.
// Assumes: Addressing-mode time comes from a separate lookup with the query.
// Notes: One query per cycle, answer registered one cycle later.
//
// Overview of operation
// - Totals include reads, prefetches, writes as triple
// - Worst case adds the next-instruction prefetch
// - Multi-register load costs 8+4n, worst 9+4n
// - Multi-register store costs 4+3n, worst 5+3n
// - General source adds fetch effective address time
// - Immediate, bounds, long forms add fetch-immediate time
// - Status word to memory adds calculate-address time
// - Multi transfers, alternate alternate_space_move add calculate-immediate time
// - Quick/immediate register destination: 0, 2, 3
// - Quick/immediate memory destination: 3, 4, 6
// - Bounds compare: 16, 18, 18, one read
// - Word multiply: 25, 27, 28
// - Long multiply: 41, 43, 44
// - Unsigned word divide: 42, 44, 44
// - Signed word divide: 54, 56, 57
// - Signed long divide: 88, 90, 91
`timescale 1ns/1ps
`include "instr_timing_map.svh"

module instr_timing_model
	import instr_timing_pkg::*;
#(
	parameter int MAX_REGS = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Query side
	input wire logic req_valid_i,
	input wire timing_req_t req_i,
	// Answer side
	output logic res_valid_o,
	output timing_res_t res_o,
	// Running account of answered queries
	input wire logic accum_clear_i,
	output logic [31:0] accum_clocks_o,
	output logic accum_sat_o
);

	// One decoded table row
	typedef struct packed {
		logic [35:0] fig;
		logic per_reg_read;
		logic per_reg_write;
		addon_kind_t addon;
		logic known;
	} row_t;

	// Builds a row from its figure and its options
	function automatic row_t make_row(input logic [35:0] fig, input logic prd,
		input logic pwr, input addon_kind_t kind);
		row_t r;
		r.fig = fig;
		r.per_reg_read = prd;
		r.per_reg_write = pwr;
		r.addon = kind;
		r.known = 1'b1;
		return r;
	endfunction : make_row

	// Saturating 16-bit clock sum
	function automatic logic [15:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[16] ? 16'hFFFF : s[15:0];
	endfunction : sat_add16

	// Saturating 8-bit bus-cycle sum
	function automatic logic [7:0] sat_add8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8] ? 8'hFF : s[7:0];
	endfunction : sat_add8

	row_t row;
	logic [7:0] base_clocks;
	logic [7:0] worst_pf;
	logic [7:0] per_reg;
	logic [15:0] reg_clocks;
	logic [7:0] reg_count8;
	logic count_bad;
	bus_triple_t own_time;
	timing_res_t res_calc;
	logic res_valid_reg;
	logic res_valid_next;
	timing_res_t res_reg;
	timing_res_t res_next;
	logic [31:0] accum_reg;
	logic [31:0] accum_next;
	logic accum_sat_reg;
	logic accum_sat_next;

	// Row lookup by instruction class
	always_comb begin
		row = '0;
		unique case (req_i.cls)
			CLS_EXCHANGE: row = make_row(`ROW_EXCHANGE, 1'b0, 1'b0, ADD_NONE);
			CLS_STATUS_TO_REG: row = make_row(`ROW_STATUS_TO_REG, 1'b0, 1'b0, ADD_NONE);
			CLS_STATUS_TO_MEM: begin
				row = make_row(`ROW_STATUS_TO_MEM, 1'b0, 1'b0, ADD_CALC_ADDR);
			end
			CLS_OPERAND_TO_FLAGS: begin
				row = make_row(`ROW_OPERAND_TO_FLAGS, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_OPERAND_TO_STATUS: begin
				row = make_row(`ROW_OPERAND_TO_STATUS, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_MULTI_LOAD: begin
				row = make_row(`ROW_MULTI_LOAD, 1'b1, 1'b0, ADD_CALC_IMM);
			end
			CLS_MULTI_STORE: begin
				row = make_row(`ROW_MULTI_STORE, 1'b0, 1'b1, ADD_CALC_IMM);
			end
			CLS_ALT_LOAD: row = make_row(`ROW_ALT_LOAD, 1'b0, 1'b0, ADD_CALC_IMM);
			CLS_ALT_STORE: row = make_row(`ROW_ALT_STORE, 1'b0, 1'b0, ADD_CALC_IMM);
			CLS_USP_MOVE: row = make_row(`ROW_USP_MOVE, 1'b0, 1'b0, ADD_NONE);
			CLS_SWAP: row = make_row(`ROW_SWAP, 1'b0, 1'b0, ADD_NONE);
			CLS_ARITH_TO_REG: begin
				row = make_row(`ROW_ARITH_TO_REG, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_ARITH_TO_MEM: begin
				row = make_row(`ROW_ARITH_TO_MEM, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_ADDR_COMPARE: begin
				row = make_row(`ROW_ADDR_COMPARE, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_BOUNDS: row = make_row(`ROW_BOUNDS, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_WORD_MUL: row = make_row(`ROW_WORD_MUL, 1'b0, 1'b0, ADD_FETCH_ADDR);
			CLS_LONG_MUL: row = make_row(`ROW_LONG_MUL, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_UWORD_DIV: row = make_row(`ROW_UWORD_DIV, 1'b0, 1'b0, ADD_FETCH_ADDR);
			CLS_ULONG_DIV: row = make_row(`ROW_ULONG_DIV, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_SWORD_DIV: row = make_row(`ROW_SWORD_DIV, 1'b0, 1'b0, ADD_FETCH_ADDR);
			CLS_SLONG_DIV: row = make_row(`ROW_SLONG_DIV, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_QUICK_TO_REG: row = make_row(`ROW_QUICK_TO_REG, 1'b0, 1'b0, ADD_NONE);
			CLS_QUICK_TO_MEM: begin
				row = make_row(`ROW_QUICK_TO_MEM, 1'b0, 1'b0, ADD_FETCH_ADDR);
			end
			CLS_IMM_TO_REG: row = make_row(`ROW_IMM_TO_REG, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_IMM_TO_MEM: row = make_row(`ROW_IMM_TO_MEM, 1'b0, 1'b0, ADD_FETCH_IMM);
			CLS_IMM_COMPARE: row = make_row(`ROW_IMM_COMPARE, 1'b0, 1'b0, ADD_FETCH_IMM);
			default: row = '0; // Undefined class code, flagged bad
		endcase
	end

	// Column select and per-register cost
	always_comb begin
		base_clocks = 8'h00;
		worst_pf = 8'h00;
		unique case (req_i.tcase)
			CASE_BEST: base_clocks = row.fig[`ROW_BEST_MSB:`ROW_BEST_LSB];
			CASE_CACHE: base_clocks = row.fig[`ROW_CACHE_MSB:`ROW_CACHE_LSB];
			CASE_WORST: begin
				base_clocks = row.fig[`ROW_WORST_MSB:`ROW_WORST_LSB];
				worst_pf = {4'h0, row.fig[`ROW_PF_MSB:`ROW_PF_LSB]};
			end
			default: base_clocks = 8'h00; // Undefined case code, flagged bad
		endcase
		reg_count8 = {3'h0, req_i.reg_count};
		count_bad = (req_i.reg_count > 5'(MAX_REGS)) && (row.per_reg_read || row.per_reg_write);
		per_reg = 8'h00;
		if (row.per_reg_read) begin
			per_reg = `LOAD_CLOCKS_PER_REG;
		end else if (row.per_reg_write) begin
			per_reg = `STORE_CLOCKS_PER_REG;
		end
		reg_clocks = 16'(per_reg * reg_count8);
	end

	// Instruction's own triple, then the addressing-mode time on top
	always_comb begin
		own_time.clocks = sat_add16({8'h00, base_clocks}, reg_clocks);
		own_time.reads = {4'h0, row.fig[`ROW_READS_MSB:`ROW_READS_LSB]};
		own_time.prefetches = worst_pf;
		own_time.writes = {4'h0, row.fig[`ROW_WRITES_MSB:`ROW_WRITES_LSB]};
		if (row.per_reg_read) begin
			own_time.reads = reg_count8;
		end
		if (row.per_reg_write) begin
			own_time.writes = reg_count8;
		end
		res_calc.total = own_time;
		res_calc.addon = row.addon;
		res_calc.bad = !row.known || (req_i.tcase == 2'h3) || count_bad;
		if (row.addon != ADD_NONE) begin
			res_calc.total.clocks = sat_add16(own_time.clocks, req_i.addr_time.clocks);
			res_calc.total.reads = sat_add8(own_time.reads, req_i.addr_time.reads);
			res_calc.total.prefetches = sat_add8(own_time.prefetches,
				req_i.addr_time.prefetches);
			res_calc.total.writes = sat_add8(own_time.writes, req_i.addr_time.writes);
		end
		if (res_calc.bad) begin
			res_calc.total = '0;
		end
	end

	// Next answer: total and triple move together
	always_comb begin
		res_valid_next = req_valid_i;
		res_next = res_reg;
		if (req_valid_i) begin
			res_next = res_calc;
		end
	end

	// Answer registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			res_valid_reg <= 1'b0;
			res_reg <= `RESULT_RESET;
		end else begin
			res_valid_reg <= res_valid_next;
			res_reg <= res_next;
		end
	end

	// Running clock account of good answers, saturating
	always_comb begin
		logic [32:0] sum;
		sum = {1'b0, accum_reg} + {17'h0_0000, res_reg.total.clocks};
		accum_next = accum_reg;
		accum_sat_next = accum_sat_reg;
		if (accum_clear_i) begin
			accum_next = `ACCUM_RESET;
			accum_sat_next = 1'b0;
		end else if (res_valid_reg && !res_reg.bad) begin
			if (sum[32]) begin
				accum_next = 32'hFFFF_FFFF;
				accum_sat_next = 1'b1;
			end else begin
				accum_next = sum[31:0];
			end
		end
	end

	// Account registers
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			accum_reg <= `ACCUM_RESET;
			accum_sat_reg <= 1'b0;
		end else begin
			accum_reg <= accum_next;
			accum_sat_reg <= accum_sat_next;
		end
	end

	// Outputs straight from flip-flops
	assign res_valid_o = res_valid_reg;
	assign res_o = res_reg;
	assign accum_clocks_o = accum_reg;
	assign accum_sat_o = accum_sat_reg;

endmodule : instr_timing_model

// file: tb/addr_time_source.sv
// Purpose: Far-side stand-in that supplies addressing-mode time with each query.
// Assumes: Modes 0 and 3 mean no extra time; modes 1 and 2 carry a fixed triple.
// Notes: Figures are plain defaults; the real lookup lives outside this block.
`timescale 1ns/1ps

module addr_time_source
	import instr_timing_pkg::*;
#(
	parameter logic [15:0] CALC_CLOCKS = 16'h0005
) (
	// Mode select
	input wire logic [1:0] mode_i,
	// Addressing-mode triple
	output bus_triple_t addr_time_o
);

	// Separate lookup of the addressing-mode triple
	always_comb begin
		case (mode_i)
			2'h1: addr_time_o = {CALC_CLOCKS, 8'h01, 8'h00, 8'h00};
			2'h2: addr_time_o = {16'h0003, 8'h00, 8'h01, 8'h00};
			default: addr_time_o = '0;
		endcase
	end

endmodule : addr_time_source

// file: tb/instr_timing_model_properties.sv
// Purpose: Port-level assertions for the instruction timing model.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached to the model by bind below.
`timescale 1ns/1ps

module instr_timing_model_properties
	import instr_timing_pkg::*;
#(
	parameter int MAX_REGS = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Query and answer
	input wire logic req_valid_i,
	input wire timing_req_t req_i,
	input wire logic res_valid_o,
	input wire timing_res_t res_o,
	// Account
	input wire logic accum_clear_i,
	input wire logic [31:0] accum_clocks_o,
	input wire logic accum_sat_o
);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Answer one edge after the taking edge
	sequence s_answer;
		##1 res_valid_o;
	endsequence

	a_answer_next: assert property (req_valid_i |-> s_answer)
		else $error("answer missing one cycle after query");
	a_no_extra: assert property (!req_valid_i |=> !res_valid_o)
		else $error("answer without query");
	a_wordmul_worst: assert property (req_valid_i && req_i.cls == CLS_WORD_MUL &&
		req_i.tcase == CASE_WORST && req_i.addr_time == '0
		|=> res_o.total.clocks == 16'h001C && res_o.total.prefetches == 8'h01)
		else $error("word multiply worst figure wrong");
	a_best_nopf: assert property (req_valid_i && req_i.tcase == CASE_BEST &&
		req_i.addr_time.prefetches == 8'h00 |=> res_o.total.prefetches == 8'h00)
		else $error("prefetch counted in best case");
	a_load_count: assert property (req_valid_i && req_i.cls == CLS_MULTI_LOAD &&
		req_i.tcase == CASE_WORST && req_i.reg_count <= MAX_REGS && req_i.addr_time == '0
		|=> res_o.total.clocks == 16'h0009 + 16'h0004 * $past(req_i.reg_count)
		&& res_o.total.reads == $past(req_i.reg_count))
		else $error("multi load count wrong");
	a_store_count: assert property (req_valid_i && req_i.cls == CLS_MULTI_STORE &&
		req_i.tcase == CASE_BEST && req_i.reg_count <= MAX_REGS && req_i.addr_time == '0
		|=> res_o.total.clocks == 16'h0004 + 16'h0003 * $past(req_i.reg_count)
		&& res_o.total.writes == $past(req_i.reg_count))
		else $error("multi store count wrong");
	a_slong_worst: assert property (req_valid_i && req_i.cls == CLS_SLONG_DIV &&
		req_i.tcase == CASE_WORST && req_i.addr_time == '0
		|=> res_o.total.clocks == 16'h005B && res_o.total.prefetches == 8'h01)
		else $error("signed long divide worst figure wrong");
	a_bad_case: assert property (req_valid_i && req_i.tcase == 2'h3
		|=> res_o.bad && res_o.total == '0)
		else $error("illegal case not flagged");
	a_clear_acc: assert property (accum_clear_i |=> accum_clocks_o == 32'h0 && !accum_sat_o)
		else $error("account not cleared");
	a_acc_adds: assert property (res_valid_o && !res_o.bad && !accum_clear_i &&
		accum_clocks_o < 32'hFFFF_0000
		|=> accum_clocks_o == $past(accum_clocks_o) + $past(res_o.total.clocks))
		else $error("account not summed");

endmodule : instr_timing_model_properties

bind instr_timing_model instr_timing_model_properties #(.MAX_REGS(MAX_REGS))
	i_instr_timing_model_properties (.clk_i(clk_i), .rstn_i(rstn_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .res_valid_o(res_valid_o), .res_o(res_o),
	.accum_clear_i(accum_clear_i), .accum_clocks_o(accum_clocks_o),
	.accum_sat_o(accum_sat_o));

// file: tb/instr_cycle_timing_model_tb.sv
// Purpose: Self-checking bench for the instruction timing model.
// Assumes: 10 MHz clock, inputs driven by non-blocking assignment at the rising edge.
// Notes: Addressing-mode time comes from the far-side stand-in.
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin \
	$display("unexpected at %0t: %s", $time, msg); n_errors++; end end

module instr_cycle_timing_model_tb;
	import instr_timing_pkg::*;

	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic accum_clear_i = 1'b0;
	instr_class_t q_cls = CLS_EXCHANGE;
	timing_case_t q_case = CASE_BEST;
	logic [4:0] q_n = 5'h00;
	logic [1:0] q_mode = 2'h0;
	bus_triple_t addr_time;
	timing_req_t req_i;
	logic res_valid_o;
	timing_res_t res_o;
	logic [31:0] accum_clocks_o;
	logic accum_sat_o;
	int n_errors = 0;
	int n_compared = 0;
	// Rows: best, cache, worst, reads nibble, writes nibble
	instr_class_t row_cls [23] = '{CLS_QUICK_TO_REG, CLS_IMM_TO_REG, CLS_IMM_COMPARE,
		CLS_QUICK_TO_MEM, CLS_IMM_TO_MEM, CLS_ARITH_TO_MEM, CLS_BOUNDS, CLS_WORD_MUL,
		CLS_LONG_MUL, CLS_UWORD_DIV, CLS_SWORD_DIV, CLS_SLONG_DIV, CLS_EXCHANGE,
		CLS_STATUS_TO_REG, CLS_STATUS_TO_MEM, CLS_OPERAND_TO_FLAGS, CLS_ALT_LOAD,
		CLS_ALT_STORE, CLS_USP_MOVE, CLS_SWAP, CLS_ARITH_TO_REG, CLS_ADDR_COMPARE,
		CLS_ULONG_DIV};
	logic [31:0] row_fig [23] = '{32'h0002_0300, 32'h0002_0300, 32'h0002_0300,
		32'h0304_0601, 32'h0304_0601, 32'h0304_0601, 32'h1012_1210, 32'h191B_1C00,
		32'h292B_2C00, 32'h2A2C_2C00, 32'h3638_3900, 32'h585A_5B00, 32'h0002_0300,
		32'h0104_0500, 32'h0505_0701, 32'h0404_0500, 32'h0707_0810, 32'h0505_0701,
		32'h0002_0300, 32'h0104_0400, 32'h0002_0300, 32'h0104_0400, 32'h4C4E_4F00};

	assign req_i = {q_cls, q_case, q_n, addr_time};

	addr_time_source i_addr_time_source (.mode_i(q_mode), .addr_time_o(addr_time));

	instr_timing_model i_instr_timing_model (.clk_i(clk_i), .rstn_i(rstn_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .res_valid_o(res_valid_o),
		.res_o(res_o), .accum_clear_i(accum_clear_i), .accum_clocks_o(accum_clocks_o),
		.accum_sat_o(accum_sat_o));

	// Clock generator
	initial begin
		forever #50 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// One query, then a bounded wait for its answer
	task automatic ask(input instr_class_t c, input timing_case_t t, input logic [4:0] n,
		input logic [1:0] m);
		bit got;
		got = 1'b0;
		@(posedge clk_i);
		q_cls <= c;
		q_case <= t;
		q_n <= n;
		q_mode <= m;
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		for (int i = 0; i < 4 && !got; i++) begin
			#1;
			if (res_valid_o === 1'b1) begin
				got = 1'b1;
			end else begin
				@(posedge clk_i);
			end
		end
		if (!got) begin
			`CHECK(1'b0, 1'b1, "no answer")
			stop_test();
		end
	endtask : ask

	// Compare the answered triple
	task automatic chk(input logic [15:0] c, input logic [7:0] r, input logic [7:0] p,
		input logic [7:0] w);
		`CHECK(res_o.bad, 1'b0, "flagged bad")
		`CHECK(res_o.total.clocks, c, "clock total")
		`CHECK(res_o.total.reads, r, "read count")
		`CHECK(res_o.total.prefetches, p, "prefetch count")
		`CHECK(res_o.total.writes, w, "write count")
	endtask : chk

	// Every fixed row in all three cases, operand-to-status in best and worst only
	task automatic t_table();
		for (int i = 0; i < 23; i++) begin
			for (int k = 0; k < 3; k++) begin
				ask(row_cls[i], timing_case_t'(k), 5'h00, 2'h0);
				chk(16'(row_fig[i][31 - 8 * k -: 8]), 8'(row_fig[i][7:4]), 8'(k == 2),
					8'(row_fig[i][3:0]));
			end
		end
		// Status load from an operand costs two prefetches in the worst case
		ask(CLS_OPERAND_TO_STATUS, CASE_WORST, 5'h00, 2'h0);
		chk(16'h000B, 8'h00, 8'h02, 8'h00);
		ask(CLS_OPERAND_TO_STATUS, CASE_BEST, 5'h00, 2'h0);
		chk(16'h0008, 8'h00, 8'h00, 8'h00);
	endtask : t_table

	// Register counts at the boundaries, one beyond the limit
	task automatic t_multi();
		ask(CLS_MULTI_LOAD, CASE_BEST, 5'h00, 2'h0);
		chk(16'h0008, 8'h00, 8'h00, 8'h00);
		ask(CLS_MULTI_LOAD, CASE_WORST, 5'h10, 2'h0);
		chk(16'h0049, 8'h10, 8'h01, 8'h00);
		ask(CLS_MULTI_STORE, CASE_WORST, 5'h10, 2'h0);
		chk(16'h0035, 8'h00, 8'h01, 8'h10);
		ask(CLS_MULTI_STORE, CASE_CACHE, 5'h02, 2'h0);
		chk(16'h000A, 8'h00, 8'h00, 8'h02);
		ask(CLS_MULTI_STORE, CASE_BEST, 5'h05, 2'h0);
		chk(16'h0013, 8'h00, 8'h00, 8'h05);
		ask(CLS_MULTI_STORE, CASE_CACHE, 5'h11, 2'h0);
		`CHECK(res_o.bad, 1'b1, "oversized list accepted")
		`CHECK(res_o.total, bus_triple_t'(0), "refused total not zero")
	endtask : t_multi

	// Addressing-mode time summed per row kind
	task automatic t_addon();
		ask(CLS_MULTI_LOAD, CASE_WORST, 5'h03, 2'h1);
		chk(16'h001A, 8'h04, 8'h01, 8'h00);
		`CHECK(res_o.addon, ADD_CALC_IMM, "load addon")
		ask(CLS_ALT_STORE, CASE_BEST, 5'h00, 2'h1);
		chk(16'h000A, 8'h01, 8'h00, 8'h01);
		ask(CLS_STATUS_TO_MEM, CASE_WORST, 5'h00, 2'h1);
		chk(16'h000C, 8'h01, 8'h01, 8'h01);
		`CHECK(res_o.addon, ADD_CALC_ADDR, "status addon")
		ask(CLS_ARITH_TO_MEM, CASE_CACHE, 5'h00, 2'h2);
		chk(16'h0007, 8'h00, 8'h01, 8'h01);
		ask(CLS_LONG_MUL, CASE_BEST, 5'h00, 2'h1);
		chk(16'h002E, 8'h01, 8'h00, 8'h00);
		`CHECK(res_o.addon, ADD_FETCH_IMM, "long multiply addon")
		ask(CLS_QUICK_TO_REG, CASE_BEST, 5'h00, 2'h1);
		chk(16'h0000, 8'h00, 8'h00, 8'h00);
	endtask : t_addon

	// Back-to-back queries into the account, a bad one skipped
	task automatic t_account();
		@(posedge clk_i);
		accum_clear_i <= 1'b1;
		q_mode <= 2'h0;
		@(posedge clk_i);
		accum_clear_i <= 1'b0;
		q_cls <= CLS_WORD_MUL;
		q_case <= CASE_BEST;
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		q_cls <= CLS_SLONG_DIV;
		q_case <= CASE_WORST;
		@(posedge clk_i);
		q_case <= timing_case_t'(2'h3);
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		`CHECK(accum_clocks_o, 32'h0000_0074, "account sum")
		`CHECK(accum_sat_o, 1'b0, "account saturated")
		@(posedge clk_i);
		accum_clear_i <= 1'b1;
		@(posedge clk_i);
		accum_clear_i <= 1'b0;
		#1;
		`CHECK(accum_clocks_o, 32'h0000_0000, "account not cleared")
	endtask : t_account

	// Main sequence
	initial begin
		repeat (7) @(posedge clk_i);
		#1;
		`CHECK(res_valid_o, 1'b0, "answer during reset")
		`CHECK(res_o, timing_res_t'(0), "result during reset")
		`CHECK(accum_clocks_o, 32'h0000_0000, "account during reset")
		`CHECK(accum_sat_o, 1'b0, "saturation during reset")
		@(posedge clk_i);
		rstn_i <= 1'b1;
		t_table();
		t_multi();
		t_addon();
		t_account();
		stop_test();
	end

endmodule : instr_cycle_timing_model_tb
